// [core/sos_top.sv]
// Overview of operation
// - relay selector accepts codes 0 to 9, resets to 1
// - selected relay condition true energises the relay, closing its contacts
// - code 0: true while drive runs with motor output enabled
// - code 1: true while powered and no fault present
// - code 2: true when output frequency equals setpoint frequency
// - code 3: true while drive is tripped or faulted
// - code 4: frequency at or above threshold; code 6: below it
// - code 5: current at or above threshold; code 7: below it
// - code 8: second analog input at or above threshold
// - code 9: drive ready to run and no trip
// - threshold percentage 0.0 to 200.0, default 100.0, for codes 4 to 8
// - hysteresis 0.0 to 100.0 percent, default 0.0, around the threshold
// - analog selector resets to 8; codes 0 to 7 drive digital 24V output
// - code 8: speed scaled zero to maximum speed, 0.1 Hz units
// - code 9: current scaled zero to 200 percent rated current, 0.1 A
// - code 10: power scaled zero to twice rated power
// - code 11: torque scaled zero to 200 percent rated current
// - same threshold serves analog selector comparison codes
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "sos_params.svh"

module sos_top
    import sos_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [5:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic drive_running,
    input wire logic drive_fault,
    input wire logic drive_ready,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] setpoint_freq,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] analog_in2,
    input wire logic [15:0] motor_power,
    input wire logic [15:0] motor_torque,
    output logic relay_energise,
    output logic digital_out,
    output logic analog_mode,
    output logic [11:0] analog_level
);

    sos_code_type relay_function;
    sos_code_type analog_function;
    sos_value_type threshold;
    sos_value_type hysteresis;
    sos_value_type max_speed;
    sos_value_type rated_current;
    sos_value_type rated_power;
    logic [2:0] compare_state;
    logic [9:0] condition;
    logic write_commit;
    logic [31:0] next_readdata;

    // merge a 16-bit field with the enabled byte lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old_value,
        input logic [31:0] data,
        input logic [3:0] lanes
    );
        logic [15:0] result;
        result = old_value;
        if (lanes[0]) begin
            result[7:0] = data[7:0];
        end
        if (lanes[1]) begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    // a request is answered one cycle after it is raised
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    assign write_commit = write && !waitrequest;

    always_comb begin
        next_readdata = 32'h0000_0000;
        unique case (address)
            `SOS_ADDR_RELAY_FUNC: next_readdata[3:0] = relay_function;
            `SOS_ADDR_ANALOG_FUNC: next_readdata[3:0] = analog_function;
            `SOS_ADDR_THRESHOLD: next_readdata[15:0] = threshold;
            `SOS_ADDR_HYSTERESIS: next_readdata[15:0] = hysteresis;
            `SOS_ADDR_MAX_SPEED: next_readdata[15:0] = max_speed;
            `SOS_ADDR_RATED_CURRENT: next_readdata[15:0] = rated_current;
            `SOS_ADDR_RATED_POWER: next_readdata[15:0] = rated_power;
            `SOS_ADDR_STATUS: next_readdata[5:0] = {compare_state, analog_mode, digital_out, relay_energise};
            `SOS_ADDR_LEVEL: next_readdata[11:0] = analog_level;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // data is loaded with the answer and kept until the next read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // out-of-range codes are dropped so the selector never holds an illegal value
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            relay_function <= `SOS_RELAY_FUNC_RESET;
        end else if (write_commit && address == `SOS_ADDR_RELAY_FUNC && byteenable[0]
                     && writedata[7:0] <= {4'h0, `SOS_RELAY_FUNC_MAX}) begin
            relay_function <= writedata[3:0];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            analog_function <= `SOS_ANALOG_FUNC_RESET;
        end else if (write_commit && address == `SOS_ADDR_ANALOG_FUNC && byteenable[0]
                     && writedata[7:0] <= {4'h0, `SOS_ANALOG_FUNC_MAX}) begin
            analog_function <= writedata[3:0];
        end
    end

    // a partial write keeps the byte whose lane is not enabled
    // threshold and hysteresis are in tenths of a percent
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            threshold <= `SOS_THRESHOLD_RESET;
        end else if (write_commit && address == `SOS_ADDR_THRESHOLD
                     && merge16(threshold, writedata, byteenable) <= `SOS_THRESHOLD_MAX) begin
            threshold <= merge16(threshold, writedata, byteenable);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hysteresis <= `SOS_HYSTERESIS_RESET;
        end else if (write_commit && address == `SOS_ADDR_HYSTERESIS
                     && merge16(hysteresis, writedata, byteenable) <= `SOS_HYSTERESIS_MAX) begin
            hysteresis <= merge16(hysteresis, writedata, byteenable);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            max_speed <= `SOS_MAX_SPEED_RESET;
        end else if (write_commit && address == `SOS_ADDR_MAX_SPEED) begin
            max_speed <= merge16(max_speed, writedata, byteenable);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rated_current <= `SOS_RATED_CURRENT_RESET;
        end else if (write_commit && address == `SOS_ADDR_RATED_CURRENT) begin
            rated_current <= merge16(rated_current, writedata, byteenable);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rated_power <= `SOS_RATED_POWER_RESET;
        end else if (write_commit && address == `SOS_ADDR_RATED_POWER) begin
            rated_power <= merge16(rated_power, writedata, byteenable);
        end
    end

    // each limit sits half the hysteresis above or below the threshold
    // comparisons in integers: 2000*q against (2*thr +/- hyst)*base avoids any divide
    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_compare
            logic [15:0] quantity;
            logic [15:0] base;
            logic [31:0] scaled_quantity;
            logic [31:0] upper_limit;
            logic [31:0] lower_limit;
            logic [16:0] twice_threshold;
            if (ch == SOS_CH_SPEED) begin : g_speed
                assign quantity = output_freq;
                assign base = max_speed;
            end else if (ch == SOS_CH_CURRENT) begin : g_current
                assign quantity = motor_current;
                assign base = rated_current;
            end else begin : g_ai2
                assign quantity = analog_in2;
                assign base = `SOS_AI_FULL_SCALE;
            end
            assign twice_threshold = {threshold, 1'b0};
            assign scaled_quantity = 32'(quantity) * 32'(`SOS_PERMILLE_TWICE);
            assign upper_limit = (32'(twice_threshold) + 32'(hysteresis)) * 32'(base);
            // a band reaching below zero means the state can never clear
            assign lower_limit = (32'(twice_threshold) >= 32'(hysteresis))
                               ? (32'(twice_threshold) - 32'(hysteresis)) * 32'(base) : 32'h0000_0000;
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    compare_state[ch] <= 1'b0;
                end else if (scaled_quantity >= upper_limit) begin
                    compare_state[ch] <= 1'b1;
                end else if (scaled_quantity < lower_limit) begin
                    compare_state[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    always_comb begin
        condition[0] = drive_running;
        condition[1] = !drive_fault;
        condition[2] = output_freq == setpoint_freq;
        condition[3] = drive_fault;
        condition[4] = compare_state[SOS_CH_SPEED];
        condition[5] = compare_state[SOS_CH_CURRENT];
        condition[6] = !compare_state[SOS_CH_SPEED];
        condition[7] = !compare_state[SOS_CH_CURRENT];
        condition[8] = compare_state[SOS_CH_AI2];
        condition[9] = drive_ready && !drive_fault;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            relay_energise <= 1'b0;
        end else begin
            relay_energise <= condition[relay_function];
        end
    end

    // the comparison codes 4 to 7 read the shared threshold states
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            analog_mode <= 1'b1;
            digital_out <= 1'b0;
        end else if (analog_function <= `SOS_ANALOG_DIGITAL_MAX) begin
            analog_mode <= 1'b0;
            digital_out <= condition[analog_function];
        end else begin
            analog_mode <= 1'b1;
            digital_out <= 1'b0;
        end
    end

    // analog conversion: level = value*4095/full, by a 12-step restoring divider
    sos_div_state_type div_state;
    logic [3:0] div_count;
    logic [27:0] div_rem;
    logic [27:0] div_den;
    logic [11:0] div_quot;
    logic [15:0] sel_value;
    logic [16:0] sel_full;

    always_comb begin
        unique case (analog_function)
            `SOS_AOUT_SPEED: begin
                sel_value = output_freq;
                sel_full = {1'b0, max_speed};
            end
            `SOS_AOUT_CURRENT: begin
                sel_value = motor_current;
                sel_full = {rated_current, 1'b0};
            end
            `SOS_AOUT_POWER: begin
                sel_value = motor_power;
                sel_full = {rated_power, 1'b0};
            end
            default: begin
                sel_value = motor_torque;
                sel_full = {rated_current, 1'b0};
            end
        endcase
    end

    // the level lags the measurement by one conversion, about 13 cycles
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_state <= SOS_DIV_IDLE;
            div_count <= 4'h0;
            div_rem <= 28'h000_0000;
            div_den <= 28'h000_0000;
            div_quot <= 12'h000;
        end else begin
            unique case (div_state)
                SOS_DIV_IDLE: begin
                    div_rem <= 28'(sel_value) * 28'(`SOS_LEVEL_FULL);
                    div_den <= 28'(sel_full) << `SOS_DIV_TOP;
                    div_quot <= 12'h000;
                    div_count <= 4'h0;
                    div_state <= SOS_DIV_RUN;
                end
                SOS_DIV_RUN: begin
                    if (div_rem >= div_den) begin
                        div_rem <= div_rem - div_den;
                        div_quot <= {div_quot[10:0], 1'b1};
                    end else begin
                        div_quot <= {div_quot[10:0], 1'b0};
                    end
                    div_den <= div_den >> 1;
                    div_count <= div_count + 4'h1;
                    if (div_count == `SOS_DIV_TOP) begin
                        div_state <= SOS_DIV_IDLE;
                    end
                end
            endcase
        end
    end

    logic div_done;
    logic saturate;
    assign div_done = div_state == SOS_DIV_RUN && div_count == `SOS_DIV_TOP;
    // full scale is held while the quantity sits at or past the top of its range
    assign saturate = 17'(sel_value) >= sel_full;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            analog_level <= 12'h000;
        end else if (analog_function <= `SOS_ANALOG_DIGITAL_MAX) begin
            analog_level <= 12'h000;
        end else if (saturate) begin
            analog_level <= `SOS_LEVEL_FULL;
        end else if (div_done) begin
            if (div_rem >= div_den) begin
                analog_level <= {div_quot[10:0], 1'b1};
            end else begin
                analog_level <= {div_quot[10:0], 1'b0};
            end
        end
    end

endmodule

`default_nettype wire

// [core/sos_params.svh]
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH

// register byte addresses
`define SOS_ADDR_RELAY_FUNC 6'h00
`define SOS_ADDR_ANALOG_FUNC 6'h04
`define SOS_ADDR_THRESHOLD 6'h08
`define SOS_ADDR_HYSTERESIS 6'h0C
`define SOS_ADDR_MAX_SPEED 6'h10
`define SOS_ADDR_RATED_CURRENT 6'h14
`define SOS_ADDR_RATED_POWER 6'h18
`define SOS_ADDR_STATUS 6'h1C
`define SOS_ADDR_LEVEL 6'h20

// reset values and legal limits
`define SOS_RELAY_FUNC_RESET 4'h1
`define SOS_RELAY_FUNC_MAX 4'h9
`define SOS_ANALOG_FUNC_RESET 4'h8
`define SOS_ANALOG_FUNC_MAX 4'hB
`define SOS_ANALOG_DIGITAL_MAX 4'h7
`define SOS_AOUT_SPEED 4'h8
`define SOS_AOUT_CURRENT 4'h9
`define SOS_AOUT_POWER 4'hA
`define SOS_THRESHOLD_RESET 16'h03E8
`define SOS_THRESHOLD_MAX 16'h07D0
`define SOS_HYSTERESIS_RESET 16'h0000
`define SOS_HYSTERESIS_MAX 16'h03E8
`define SOS_MAX_SPEED_RESET 16'h01F4
`define SOS_RATED_CURRENT_RESET 16'h0064
`define SOS_RATED_POWER_RESET 16'h0064

// percentage arithmetic in tenths: 2 x 1000 per mille
`define SOS_PERMILLE_TWICE 16'h07D0
`define SOS_AI_FULL_SCALE 16'h03E8

// analog output converter
`define SOS_LEVEL_BITS 12
`define SOS_LEVEL_FULL 12'hFFF
`define SOS_DIV_STEPS 4'hC
`define SOS_DIV_TOP 4'hB

`endif

// [core/sos_pkg.sv]
`default_nettype none
package sos_pkg;
    typedef logic [3:0] sos_code_type;
    typedef logic [15:0] sos_value_type;
    typedef enum logic [0:0] {SOS_DIV_IDLE, SOS_DIV_RUN} sos_div_state_type;
    typedef enum logic [1:0] {SOS_CH_SPEED, SOS_CH_CURRENT, SOS_CH_AI2} sos_channel_type;
endpackage
`default_nettype wire

// [verif/sos_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module sos_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic drive_running,
    input wire logic drive_fault,
    input wire logic drive_ready,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] setpoint_freq,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] analog_in2,
    input wire logic relay_energise,
    input wire logic digital_out,
    input wire logic analog_mode,
    input wire logic [11:0] analog_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [66:0] drive_inputs;
    assign drive_inputs = {drive_running, drive_fault, drive_ready, output_freq, setpoint_freq, motor_current, analog_in2};
    a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("answer lasted more than one cycle");
    a_wait_cause: assert property (!waitrequest |-> $past(read || write))
        else $error("answer without request");
    a_digital_quiet: assert property (analog_mode |-> !digital_out)
        else $error("digital output high in analog mode");
    a_level_quiet: assert property (!analog_mode [*3] |-> analog_level == 12'h000)
        else $error("analog level driven in digital mode");
    // four samples cover the two-edge lag of the threshold codes
    a_relay_steady: assert property ((!write && $stable(drive_inputs)) [*4] |-> $stable(relay_energise))
        else $error("relay moved with steady inputs");
    a_digital_steady: assert property ((!write && $stable(drive_inputs)) [*4] |-> $stable(digital_out))
        else $error("digital output moved with steady inputs");
    a_mode_steady: assert property (!write [*4] |-> $stable(analog_mode))
        else $error("analog mode moved without a write");
    c_relay_on: cover property ($rose(relay_energise));
    c_digital_on: cover property ($rose(digital_out));
    c_mode_digital: cover property ($fell(analog_mode));
endmodule
bind sos_top sos_checker checker_inst (.clock(clock), .resetn(resetn), .read(read), .write(write),
    .waitrequest(waitrequest), .drive_running(drive_running), .drive_fault(drive_fault),
    .drive_ready(drive_ready), .output_freq(output_freq), .setpoint_freq(setpoint_freq),
    .motor_current(motor_current), .analog_in2(analog_in2), .relay_energise(relay_energise),
    .digital_out(digital_out), .analog_mode(analog_mode), .analog_level(analog_level));
`default_nettype wire

// [verif/sos_relay_load.sv]
`timescale 1ns/1ns
`default_nettype none
module sos_relay_load (
    input wire logic relay_energise,
    input wire logic digital_out,
    input wire logic analog_mode,
    input wire logic [11:0] analog_level,
    output logic contacts_closed,
    output logic [4:0] terminal_volts,
    output logic [11:0] meter_reading
);
    // contact bounce is not modelled, so the bench sees the coil state at once
    assign contacts_closed = relay_energise;
    assign terminal_volts = (!analog_mode && digital_out) ? 5'h18 : 5'h00;
    assign meter_reading = analog_mode ? analog_level : 12'h000;
endmodule
`default_nettype wire

// [verif/status_output_selector_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sos_params.svh"
module status_output_selector_test;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] address = 6'h00;
    logic [3:0] byteenable = 4'hF;
    logic read = 1'b0, write = 1'b0, drive_running = 1'b0, drive_fault = 1'b0, drive_ready = 1'b0;
    logic [31:0] writedata = 32'h0, readdata, rdata;
    logic [15:0] output_freq = 16'h0, setpoint_freq = 16'h0, motor_current = 16'h0, analog_in2 = 16'h0;
    logic [15:0] motor_power = 16'h0, motor_torque = 16'h0;
    logic waitrequest, relay_energise, digital_out, analog_mode, contacts_closed;
    logic [11:0] analog_level, meter_reading;
    logic [4:0] terminal_volts;
    int num_errors = 0, samples_checked = 0;
    always #20 clock = ~clock;
    sos_top uut (.clock(clock), .resetn(resetn), .address(address), .byteenable(byteenable), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .drive_running(drive_running), .drive_fault(drive_fault), .drive_ready(drive_ready),
        .output_freq(output_freq), .setpoint_freq(setpoint_freq), .motor_current(motor_current),
        .analog_in2(analog_in2), .motor_power(motor_power), .motor_torque(motor_torque),
        .relay_energise(relay_energise), .digital_out(digital_out), .analog_mode(analog_mode),
        .analog_level(analog_level));
    sos_relay_load load (.relay_energise(relay_energise), .digital_out(digital_out), .analog_mode(analog_mode),
        .analog_level(analog_level), .contacts_closed(contacts_closed), .terminal_volts(terminal_volts),
        .meter_reading(meter_reading));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // waitrequest is read right after the edge, before the slave's update lands
    task automatic bus(input logic rd, input logic [5:0] addr, input logic [31:0] data);
        @(posedge clock);
        address <= addr;
        writedata <= data;
        read <= rd;
        write <= !rd;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic expect_reg(input logic [5:0] addr, input logic [31:0] exp);
        bus(1'b1, addr, 32'h0);
        check("register", rdata, exp);
    endtask
    task automatic drive(input logic [2:0] flags, input logic [15:0] fq, sp, cur, ai);
        @(posedge clock);
        {drive_running, drive_fault, drive_ready} <= flags;
        output_freq <= fq;
        setpoint_freq <= sp;
        motor_current <= cur;
        analog_in2 <= ai;
    endtask
    task automatic select(input logic [3:0] rc, input logic [3:0] ac);
        bus(1'b0, `SOS_ADDR_RELAY_FUNC, {28'h0, rc});
        bus(1'b0, `SOS_ADDR_ANALOG_FUNC, {28'h0, ac});
        repeat (3) @(posedge clock);
    endtask
    task automatic test_reset();
        expect_reg(`SOS_ADDR_RELAY_FUNC, 32'h1);
        expect_reg(`SOS_ADDR_ANALOG_FUNC, 32'h8);
        expect_reg(`SOS_ADDR_THRESHOLD, 32'h3E8);
        expect_reg(`SOS_ADDR_HYSTERESIS, 32'h0);
        check("mode", analog_mode, 1'b1);
        check("healthy", contacts_closed, 1'b1);
    endtask
    task automatic test_codes();
        logic [9:0] masks [3] = '{10'h207, 10'h008, 10'h202};
        logic [2:0] flags [3] = '{3'h5, 3'h3, 3'h1};
        logic [15:0] sps [3] = '{16'h0064, 16'h0032, 16'h000A};
        logic [15:0] fqs [3] = '{16'h0064, 16'h0064, 16'h0000};
        logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
        for (int v = 0; v < 3; v++) begin
            drive(flags[v], fqs[v], sps[v], 16'h0, 16'h0);
            foreach (codes[i]) begin
                select(codes[i], codes[i] < 4'h4 ? codes[i] : 4'h8);
                check("relay", contacts_closed, masks[v][codes[i]]);
                check("digital", terminal_volts == 5'h18, codes[i] < 4'h4 && masks[v][codes[i]]);
            end
        end
        bus(1'b0, `SOS_ADDR_RELAY_FUNC, 32'hA);
        expect_reg(`SOS_ADDR_RELAY_FUNC, 32'h9);
    endtask
    task automatic test_thresholds();
        logic [15:0] fq [2] = '{16'h00F9, 16'h00FA};
        logic [15:0] cur [2] = '{16'h0031, 16'h0032};
        logic [15:0] ai [2] = '{16'h01F3, 16'h01F4};
        logic e;
        bus(1'b0, `SOS_ADDR_THRESHOLD, 32'h1F4);
        for (int v = 0; v < 2; v++) begin
            drive(3'h0, fq[v], 16'h0, cur[v], ai[v]);
            for (int c = 4; c < 9; c++) begin
                e = (c == 6 || c == 7) ? (v == 0) : (v == 1);
                select(4'(c), 4'(c));
                check("limit", relay_energise, e);
                check("limit digital", digital_out, e && c < 8);
            end
        end
    endtask
    task automatic test_hysteresis();
        logic [15:0] q [5] = '{16'h00C8, 16'h0104, 16'h0118, 16'h00E6, 16'h00DC};
        logic e [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        bus(1'b0, `SOS_ADDR_HYSTERESIS, 32'h64);
        select(4'h4, 4'h4);
        foreach (q[i]) begin
            drive(3'h0, q[i], 16'h0, 16'h0, 16'h0);
            repeat (3) @(posedge clock);
            check("band", relay_energise, e[i]);
        end
        bus(1'b0, `SOS_ADDR_THRESHOLD, 32'h7D1);
        expect_reg(`SOS_ADDR_THRESHOLD, 32'h1F4);
    endtask
    task automatic test_analog();
        logic [11:0] exp [4] = '{12'h7FF, 12'h7FF, 12'hFFF, 12'h3FF};
        drive(3'h0, 16'h00FA, 16'h0, 16'h0064, 16'h0);
        motor_power <= 16'h00C8;
        motor_torque <= 16'h0032;
        for (int i = 0; i < 4; i++) begin
            select(4'h1, 4'(8 + i));
            repeat (30) @(posedge clock);
            check("mode", analog_mode, 1'b1);
            check("level", meter_reading, exp[i]);
        end
        bus(1'b0, `SOS_ADDR_ANALOG_FUNC, 32'hC);
        expect_reg(`SOS_ADDR_ANALOG_FUNC, 32'hB);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        test_reset();
        test_codes();
        test_thresholds();
        test_hysteresis();
        test_analog();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
